// File: tb.sv
`timescale 1ns/1ps
module tb;
  import wdc_pkg::*;
  logic        clk_i            = 1'b0;
  logic        nrst_i           = 1'b0;
  logic [3:0]  avs_address_i    = 4'h0;
  logic        avs_read_i       = 1'b0;
  logic        avs_write_i      = 1'b0;
  logic [31:0] avs_writedata_i  = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        wdt_osc_i        = 1'b0;
  logic        kick_i           = 1'b0;
  logic        always_on_fuse_i = 1'b0;
  logic        ext_rst_i        = 1'b0;
  logic        bor_rst_i        = 1'b0;
  logic        scan_rst_i       = 1'b0;
  logic        wdt_rst_o;
  logic        wdt_enabled_o;
  logic        level2_o;
  logic [31:0] rdata;
  int          mismatches       = 0;
  int          n_tests          = 0;

  wdc_watchdog #(.TIMEOUT_BASE(4)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .wdt_osc_i(wdt_osc_i), .kick_i(kick_i),
    .always_on_fuse_i(always_on_fuse_i), .ext_rst_i(ext_rst_i),
    .bor_rst_i(bor_rst_i), .scan_rst_i(scan_rst_i), .wdt_rst_o(wdt_rst_o),
    .wdt_enabled_o(wdt_enabled_o), .level2_o(level2_o)
  );

  always #25 clk_i = ~clk_i;
  // free-running 1 MHz watchdog oscillator
  always #500 wdt_osc_i = ~wdt_osc_i;

  task automatic tally_and_finish;
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d);
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    // only the watchdog process ends a wait that never completes
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rdata = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp,
                    input string what);
    bus(1'b0, a, 8'h00);
    cmp(what, {24'h0, exp}, rdata);
  endtask

  task automatic do_reset(input logic fuse);
    @(posedge clk_i);
    always_on_fuse_i <= fuse;
    nrst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic t_reset_l1;
    do_reset(1'b0);
    rd(FLAGS_OFS, 8'h01, "flags after power-on");
    rd(CTRL_OFS, 8'h00, "ctrl after power-on");
    cmp("enabled after power-on", 32'h0, {31'h0, wdt_enabled_o});
    cmp("level2 out low", 32'h0, {31'h0, level2_o});
    rd(4'h8, 8'h00, "unmapped read");
  endtask

  task automatic t_enable_lock;
    kick_i <= 1'b1;
    avs_byteenable_i <= 4'h0;
    wr(CTRL_OFS, 8'h08);
    avs_byteenable_i <= 4'hF;
    rd(CTRL_OFS, 8'h00, "ctrl byte lane off");
    wr(4'h8, 8'h08);
    rd(CTRL_OFS, 8'h00, "ctrl unmapped write");
    wr(CTRL_OFS, 8'h08);
    rd(CTRL_OFS, 8'h08, "ctrl free enable");
    cmp("enabled out", 32'h1, {31'h0, wdt_enabled_o});
    wr(CTRL_OFS, 8'h00);
    wr(CTRL_OFS, 8'hEF);
    rd(CTRL_OFS, 8'h08, "ctrl locked write");
    wr(CTRL_OFS, 8'h18);
    rd(CTRL_OFS, 8'h18, "ctrl window open");
    rd(CTRL_OFS, 8'h08, "ctrl window lapsed");
    wr(CTRL_OFS, 8'h00);
    rd(CTRL_OFS, 8'h08, "ctrl after lapse");
    wr(CTRL_OFS, 8'h18);
    wr(CTRL_OFS, 8'h05);
    rd(CTRL_OFS, 8'h05, "ctrl timed change");
    cmp("disabled out", 32'h0, {31'h0, wdt_enabled_o});
    wr(CTRL_OFS, 8'h10);
    wr(CTRL_OFS, 8'h03);
    rd(CTRL_OFS, 8'h05, "ctrl unlock without enable");
    kick_i <= 1'b0;
  endtask

  task automatic t_timeout(input logic [2:0] sel);
    int n;
    int ticks;
    logic seen;
    seen = 1'b0;
    ticks = 4 << sel;
    wr(FLAGS_OFS, 8'h00);
    kick_i <= 1'b1;
    wr(CTRL_OFS, 8'h18);
    wr(CTRL_OFS, {5'h01, sel});
    // held kick must keep the counter from expiring
    repeat (200) begin
      @(posedge clk_i);
      if (wdt_rst_o === 1'b1)
        seen = 1'b1;
    end
    cmp("pulse under kick", 32'h0, {31'h0, seen});
    kick_i <= 1'b0;
    n = 0;
    while (wdt_rst_o !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    cmp("expiry in span", 32'h1,
        {31'h0, n >= (ticks - 1) * 20 && n <= (ticks + 1) * 20 + 6});
    @(posedge clk_i);
    cmp("pulse one cycle", 32'h0, {31'h0, wdt_rst_o});
    repeat (4) @(posedge clk_i);
    rd(CTRL_OFS, 8'h00, "ctrl after expiry");
    rd(FLAGS_OFS, 8'h08, "flags after expiry");
  endtask

  task automatic t_flags;
    int b;
    wr(FLAGS_OFS, 8'h00);
    rd(FLAGS_OFS, 8'h00, "flags cleared");
    for (int i = 0; i < 3; i++) begin
      b = (i == 0) ? 1 : (i == 1) ? 2 : 4;
      @(posedge clk_i);
      ext_rst_i  <= (b == 1);
      bor_rst_i  <= (b == 2);
      scan_rst_i <= (b == 4);
      repeat (4) @(posedge clk_i);
      ext_rst_i  <= 1'b0;
      bor_rst_i  <= 1'b0;
      scan_rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rd(FLAGS_OFS, 8'h01 << b, "flag set by source");
      wr(FLAGS_OFS, 8'h1F);
      rd(FLAGS_OFS, 8'h01 << b, "flag kept by one");
      wr(FLAGS_OFS, 8'h00);
      rd(FLAGS_OFS, 8'h00, "flag cleared by zero");
    end
  endtask

  task automatic t_level2;
    kick_i <= 1'b1;
    do_reset(1'b1);
    rd(FLAGS_OFS, 8'h01, "flags after power-on");
    cmp("level2 out", 32'h1, {31'h0, level2_o});
    cmp("enabled level2", 32'h1, {31'h0, wdt_enabled_o});
    rd(CTRL_OFS, 8'h08, "ctrl level2");
    wr(CTRL_OFS, 8'h00);
    rd(CTRL_OFS, 8'h08, "ctrl level2 plain off");
    wr(CTRL_OFS, 8'h18);
    wr(CTRL_OFS, 8'h02);
    rd(CTRL_OFS, 8'h0A, "ctrl level2 timed");
    wr(CTRL_OFS, 8'h03);
    rd(CTRL_OFS, 8'h0A, "ctrl level2 locked");
    cmp("enabled stays", 32'h1, {31'h0, wdt_enabled_o});
  endtask

  initial begin
    #500000;
    mismatches++;
    tally_and_finish;
  end

  initial begin
    t_reset_l1;
    t_enable_lock;
    t_timeout(3'h0);
    t_timeout(3'h2);
    t_flags;
    t_level2;
    tally_and_finish;
  end
endmodule // tb

// File: wdc_pkg.sv
package wdc_pkg;

  // register map, byte addresses on the Avalon slave
  localparam int unsigned ADDR_W         = 4;
  localparam logic [3:0]  CTRL_OFS       = 4'h0;
  localparam logic [3:0]  FLAGS_OFS      = 4'h4;

  // watchdog_control fields
  localparam int unsigned SEL_LSB        = 0;
  localparam int unsigned SEL_W          = 3;
  localparam int unsigned EN_BIT         = 3;
  localparam int unsigned CUE_BIT        = 4;

  // reset_cause_flags fields
  localparam int unsigned POR_FLAG_BIT   = 0;
  localparam int unsigned EXT_FLAG_BIT   = 1;
  localparam int unsigned BOR_FLAG_BIT   = 2;
  localparam int unsigned WDT_FLAG_BIT   = 3;
  localparam int unsigned SCAN_FLAG_BIT  = 4;
  localparam int unsigned FLAGS_W        = 5;

  // values after reset
  localparam logic [4:0]  FLAGS_RST      = 5'h01;
  localparam logic [2:0]  SEL_RST        = 3'h0;

  // unlock window, in system clock cycles
  localparam logic [2:0]  UNLOCK_CYC     = 3'h4;

  // shortest time-out, in watchdog oscillator cycles (16K)
  localparam int unsigned TIMEOUT_BASE_OSC = 16384;
  localparam int unsigned CNT_W          = 22;

  typedef enum logic [1:0] {
    WDC_BUS_IDLE = 2'b01,
    WDC_BUS_ACK  = 2'b10
  } wdc_bus_state_t;

endpackage

// File: wdc_sync.sv
`timescale 1ns/1ps
module wdc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] safe_reg;

  // first stage is read by the second stage only
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= '0;
      safe_reg <= '0;
    end else begin
      meta_reg <= d_i;
      safe_reg <= meta_reg;
    end
  end

  assign q_o = safe_reg;

endmodule // wdc_sync

// File: wdc_watchdog.sv
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
// Functional notes
// - level 1 starts disabled; writing enable one enables freely
// - level 1 takes enable and select from one write within four cycles
// - level 2 keeps the watchdog enabled; enable reads as one
// - level 2 window write changes select only, enable value ignored
// - level 2 watchdog cannot be disabled by any write sequence
// - hardware clears unlock bit four clock cycles after it is set
// - enable one enables; enable zero disables only while unlocked
// - select changes only while the unlock bit is set, or on a chip reset
// - control bits seven to five read as zero
// - select codes give 16K up to 2048K oscillator cycles
// - scan flag set by scan reset, cleared by power-on or write zero
// - watchdog flag set by watchdog reset, cleared likewise
// - brown-out flag set by brown-out reset, cleared likewise
// - external flag set by pin reset, cleared likewise
// - power-on flag set by power-on, cleared only by write zero
// - counter runs on 1 MHz oscillator; restarts on kick, disable, reset
// - always-on fuse selects level 1 or level 2
// - expiry while enabled gives a one-cycle reset pulse
module wdc_watchdog #(
  parameter int unsigned TIMEOUT_BASE = wdc_pkg::TIMEOUT_BASE_OSC
) (
  input  wire logic                       clk_i,
  input  wire logic                       nrst_i,
  input  wire logic [wdc_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [31:0]                avs_writedata_i,
  input  wire logic [3:0]                 avs_byteenable_i,
  output logic      [31:0]                avs_readdata_o,
  output logic                            avs_waitrequest_o,
  input  wire logic                       wdt_osc_i,
  input  wire logic                       kick_i,
  input  wire logic                       always_on_fuse_i,
  input  wire logic                       ext_rst_i,
  input  wire logic                       bor_rst_i,
  input  wire logic                       scan_rst_i,
  output logic                            wdt_rst_o,
  output logic                            wdt_enabled_o,
  output logic                            level2_o
);
  import wdc_pkg::*;

  // asynchronous inputs, two flip-flops each
  logic [4:0]           sync_q;
  logic                 osc_s;
  logic                 fuse_s;
  logic                 ext_s;
  logic                 bor_s;
  logic                 scan_s;
  logic                 osc_prev_reg;
  logic                 osc_tick;

  // bus slave
  wdc_bus_state_t       bus_state_reg;
  logic                 req;
  logic                 acc;
  logic                 wr_acc;
  logic [7:0]           wd;
  logic [31:0]          rdata_reg;
  logic [7:0]           rd8;
  logic                 rd8_en_ok;

  // control state
  logic                 ctrl_wr;
  logic                 flag_wr;
  logic                 unlock_wr;
  logic                 change_wr;
  logic                 unlock_open;
  logic [2:0]           unlock_cnt_reg;
  logic                 enable_reg;
  logic [SEL_W-1:0]     sel_reg;
  logic                 level2;
  logic                 wdt_en;
  logic                 expire;
  logic                 chip_rst;
  logic [FLAGS_W-1:0]   flags_reg;
  logic [FLAGS_W-1:0]   flag_set;
  logic                 level2_reg;
  logic                 wdt_en_reg;

  wdc_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    ({wdt_osc_i, always_on_fuse_i, ext_rst_i, bor_rst_i,
              scan_rst_i}),
    .q_o    (sync_q)
  );

  assign osc_s  = sync_q[4];
  assign fuse_s = sync_q[3];
  assign ext_s  = sync_q[2];
  assign bor_s  = sync_q[1];
  assign scan_s = sync_q[0];

  // rising edge of the watchdog oscillator
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_prev_reg <= 1'b0;
    end else begin
      osc_prev_reg <= osc_s;
    end
  end

  assign osc_tick = osc_s && !osc_prev_reg;

  // ---- Avalon-MM slave: one wait state on every access
  assign req = avs_read_i || avs_write_i;
  assign acc = req && (bus_state_reg == WDC_BUS_ACK);
  assign wr_acc = acc && avs_write_i;
  assign wd = avs_writedata_i[7:0];
  assign avs_waitrequest_o = req && (bus_state_reg != WDC_BUS_ACK);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_state_reg <= WDC_BUS_IDLE;
    end else begin
      case (bus_state_reg)
        WDC_BUS_IDLE: begin
          if (req) begin
            bus_state_reg <= WDC_BUS_ACK;
          end
        end
        WDC_BUS_ACK: begin
          bus_state_reg <= WDC_BUS_IDLE;
        end
        default: begin
          bus_state_reg <= WDC_BUS_IDLE;
        end
      endcase
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rd8 = 8'h00;
    if (avs_address_i == CTRL_OFS) begin
      rd8 = {3'h0, unlock_open, wdt_en, sel_reg};
    end else if (avs_address_i == FLAGS_OFS) begin
      rd8 = {3'h0, flags_reg};
    end
  end

  assign rd8_en_ok = (avs_address_i != CTRL_OFS) || rd8[EN_BIT];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read_i && bus_state_reg == WDC_BUS_IDLE) begin
      rdata_reg <= {24'h00_0000, rd8};
    end
  end

  assign avs_readdata_o = rdata_reg;

  // ---- register writes, byte lane 0 carries the 8-bit registers
  assign ctrl_wr = wr_acc && (avs_address_i == CTRL_OFS)
                   && avs_byteenable_i[0];
  assign flag_wr = wr_acc && (avs_address_i == FLAGS_OFS)
                   && avs_byteenable_i[0];

  assign unlock_open = (unlock_cnt_reg != 3'h0);
  assign unlock_wr   = ctrl_wr && wd[CUE_BIT] && wd[EN_BIT];
  assign change_wr   = ctrl_wr && !wd[CUE_BIT] && unlock_open;

  // watchdog reset and the other reset sources restart the block
  assign chip_rst = ext_s || bor_s || scan_s || expire;

  // fuse programmed selects level 2
  assign level2 = fuse_s;
  assign wdt_en = enable_reg || level2;

  // unlock window counts down and closes itself
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      unlock_cnt_reg <= 3'h0;
    end else if (chip_rst) begin
      unlock_cnt_reg <= 3'h0;
    end else if (unlock_wr) begin
      unlock_cnt_reg <= UNLOCK_CYC;
    end else if (change_wr) begin
      unlock_cnt_reg <= 3'h0;
    end else if (unlock_open) begin
      unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
    end
  end

  // enable: set freely, cleared through the window or by chip_rst
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable_reg <= 1'b0;
    end else if (chip_rst) begin
      enable_reg <= 1'b0;
    end else if (ctrl_wr && wd[EN_BIT]) begin
      enable_reg <= 1'b1;
    end else if (change_wr) begin
      enable_reg <= 1'b0;
    end
  end

  // select: only a qualifying window write or chip_rst changes it
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_reg <= SEL_RST;
    end else if (chip_rst) begin
      sel_reg <= SEL_RST;
    end else if (change_wr) begin
      sel_reg <= wd[SEL_LSB +: SEL_W];
    end
  end

  wdc_wdt_counter #(
    .BASE  (TIMEOUT_BASE),
    .CNT_W (CNT_W)
  ) u_counter (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .tick_i    (osc_tick),
    .restart_i (kick_i || !wdt_en || chip_rst),
    .sel_i     (sel_reg),
    .expire_o  (expire)
  );

  assign wdt_rst_o = expire;

  // ---- reset cause flags; a set beats a write of zero
  assign flag_set = {scan_s, expire, bor_s, ext_s, 1'b0};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_reg <= FLAGS_RST;
    end else if (flag_wr) begin
      flags_reg <= (flags_reg & wd[FLAGS_W-1:0]) | flag_set;
    end else begin
      flags_reg <= flags_reg | flag_set;
    end
  end

  // status outputs
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      level2_reg <= 1'b0;
      wdt_en_reg <= 1'b0;
    end else begin
      level2_reg <= level2;
      wdt_en_reg <= wdt_en;
    end
  end

  assign level2_o      = level2_reg;
  assign wdt_enabled_o = wdt_en_reg;

  // ---- checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_unlock_quiet;
    unlock_wr && !chip_rst ##1 (!ctrl_wr && !chip_rst) [*4];
  endsequence

  sequence s_locked_zero_write;
    ctrl_wr && !wd[EN_BIT] && !unlock_open && !chip_rst;
  endsequence

  sequence s_window_untouched;
    unlock_wr && !chip_rst ##1 (!change_wr && !chip_rst) [*3];
  endsequence

  chk_unlock_closes: assert property (
    s_unlock_quiet |=> !unlock_open)
    else $error("unlock bit not cleared after four cycles");

  chk_unlock_opens: assert property (
    s_window_untouched |=> unlock_open)
    else $error("unlock window shorter than four cycles");

  chk_level1_enable: assert property (
    ctrl_wr && wd[EN_BIT] && !chip_rst |=> wdt_en)
    else $error("enable write did not enable watchdog");

  chk_level2_on: assert property (
    level2 |-> wdt_en && rd8_en_ok)
    else $error("level 2 watchdog found disabled");

  chk_locked_disable: assert property (
    s_locked_zero_write |=> enable_reg == $past(enable_reg))
    else $error("enable cleared without unlock");

  chk_sel_locked: assert property (
    !change_wr && !chip_rst |=> sel_reg == $past(sel_reg))
    else $error("select changed outside the window");

  chk_window_write: assert property (
    change_wr && !chip_rst |=> sel_reg == $past(wd[2:0])
      && !unlock_open && (enable_reg == $past(wd[EN_BIT])))
    else $error("window write not applied");

  chk_wdt_flag: assert property (
    expire |=> flags_reg[WDT_FLAG_BIT] ##1 !expire)
    else $error("watchdog reset not flagged");

  chk_por_flag_kept: assert property (
    flags_reg[POR_FLAG_BIT] && !(flag_wr && !wd[POR_FLAG_BIT])
      |=> flags_reg[POR_FLAG_BIT])
    else $error("power-on flag lost without write");

  chk_rsvd_zero: assert property (
    acc && avs_read_i |-> avs_readdata_o[31:5] == 27'h0)
    else $error("reserved bits read nonzero");

  chk_pulse_one: assert property (
    expire |=> !expire && !wdt_rst_o)
    else $error("watchdog reset longer than one cycle");

  chk_flag_sources: assert property (
    flag_set != '0 |=> (flags_reg & $past(flag_set)) == $past(flag_set))
    else $error("reset source not flagged");

  chk_flag_clear: assert property (
    flag_wr && flag_set == '0
      |=> flags_reg == ($past(flags_reg) & $past(wd[FLAGS_W-1:0])))
    else $error("flag write not applied");

  chk_level2_sel: assert property (
    change_wr && level2 && !chip_rst
      |=> wdt_en && sel_reg == $past(wd[SEL_LSB +: SEL_W]))
    else $error("level 2 window write mishandled");

  chk_lapse_keeps: assert property (
    unlock_cnt_reg == 3'h1 && !unlock_wr && !change_wr && !chip_rst
      |=> !unlock_open && enable_reg == $past(enable_reg)
      && sel_reg == $past(sel_reg))
    else $error("window lapse changed the configuration");

  chk_unlock_needs_en: assert property (
    ctrl_wr && wd[CUE_BIT] && !wd[EN_BIT] && !unlock_open && !chip_rst
      |=> !unlock_open)
    else $error("window opened without enable bit");

endmodule // wdc_watchdog

// File: wdc_wdt_counter.sv
`timescale 1ns/1ps
module wdc_wdt_counter #(
  parameter int unsigned BASE  = wdc_pkg::TIMEOUT_BASE_OSC,
  parameter int unsigned CNT_W = wdc_pkg::CNT_W
) (
  input  wire logic                      clk_i,
  input  wire logic                      nrst_i,
  input  wire logic                      tick_i,
  input  wire logic                      restart_i,
  input  wire logic [wdc_pkg::SEL_W-1:0] sel_i,
  output logic                           expire_o
);
  import wdc_pkg::*;

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] limit;
  logic             expire_reg;
  logic             hit;

  // time-out doubles with each select code
  assign limit = CNT_W'(BASE) << sel_i;
  assign hit   = tick_i && (count_reg == limit - CNT_W'(1));

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_reg <= '0;
    end else if (restart_i || hit) begin
      count_reg <= '0;
    end else if (tick_i) begin
      count_reg <= count_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      expire_reg <= 1'b0;
    end else begin
      expire_reg <= hit && !restart_i;
    end
  end

  assign expire_o = expire_reg;

  chk_restart_clears: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    restart_i |=> (count_reg == '0) && !expire_reg)
    else $error("counter not cleared by restart");

endmodule // wdc_wdt_counter
